// >>> pim_pin_host.sv
// far side model: device pins and processor event input
`timescale 1ns/1ps
module pim_pin_host
	import pim_pkg::*;
(
	input  wire logic                core_clk_in,
	input  wire logic [NUM_PINS-1:0] tgt_in,
	input  wire logic                event_in,
	output logic      [NUM_PINS-1:0] pins_out,
	output logic                     ev_seen_out
);
	initial begin
		pins_out = '0;
		ev_seen_out = 1'b0;
	end
	// pins change only after a clock edge
	always @(posedge core_clk_in) begin
		pins_out <= tgt_in;
		ev_seen_out <= ev_seen_out | (event_in === 1'b1);
	end
endmodule

// >>> pim_pkg.sv
// constants, register map and types for the pin interrupt and pattern match block
package pim_pkg;
	localparam int NUM_SRC     = 8;
	localparam int NUM_PINS    = 64;
	localparam int SEL_W       = 6;
	localparam int ADDR_W      = 6;
	localparam int DATA_W      = 32;

	// register byte addresses
	localparam logic [ADDR_W-1:0] REG_MODE     = 6'h00;
	localparam logic [ADDR_W-1:0] REG_RISE_EN  = 6'h04;
	localparam logic [ADDR_W-1:0] REG_FALL_EN  = 6'h08;
	localparam logic [ADDR_W-1:0] REG_LVL_POL  = 6'h0C;
	localparam logic [ADDR_W-1:0] REG_RISE_PND = 6'h10;
	localparam logic [ADDR_W-1:0] REG_FALL_PND = 6'h14;
	localparam logic [ADDR_W-1:0] REG_MATCH_EN = 6'h18;
	localparam logic [ADDR_W-1:0] REG_SEL_LO   = 6'h1C;
	localparam logic [ADDR_W-1:0] REG_SEL_HI   = 6'h20;
	localparam logic [ADDR_W-1:0] REG_SLICE_LO = 6'h24;
	localparam logic [ADDR_W-1:0] REG_SLICE_HI = 6'h28;
	localparam logic [ADDR_W-1:0] REG_ENDPT    = 6'h2C;
	localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 6'h30;
	localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 6'h34;
	localparam logic [ADDR_W-1:0] REG_PIN_STAT = 6'h38;

	// field positions in the match enable register
	localparam int MATCH_EN_BIT  = 0;
	localparam int EVENT_EN_BIT  = 1;

	// reset values
	localparam logic [NUM_SRC-1:0]   RST_BYTE   = 8'h00;
	localparam logic [NUM_SRC*3-1:0] RST_SLICE  = 24'h000000;
	localparam logic [DATA_W-1:0]    RST_SEL    = 32'h00000000;
	localparam logic [DATA_W-1:0]    UNMAPPED_RD = 32'h00000000;

	// slice condition codes
	typedef enum logic [2:0] {
		PIM_COND_TRUE   = 3'h0,
		PIM_COND_HIGH   = 3'h1,
		PIM_COND_LOW    = 3'h2,
		PIM_COND_RISE   = 3'h3,
		PIM_COND_FALL   = 3'h4,
		PIM_COND_EDGE   = 3'h5,
		PIM_COND_HI_ST  = 3'h6,
		PIM_COND_LO_ST  = 3'h7
	} pim_cond_t;
endpackage

// >>> pim_slice.sv
`timescale 1ns/1ps
// one product-term slice of the pattern matcher
module pim_slice
	import pim_pkg::*;
(
	input  wire logic       core_clk_in,
	input  wire logic       srst_in,
	input  wire logic       level_in,
	input  wire logic       rise_in,
	input  wire logic       fall_in,
	input  wire logic [2:0] cond_in,
	input  wire logic       clr_in,
	output logic            hit_out
);
	logic sticky_r;
	logic sticky_nxt;
	logic edge_ev;

	always_comb begin
		edge_ev    = 1'b0;
		sticky_nxt = sticky_r;
		case (pim_cond_t'(cond_in))
			PIM_COND_HI_ST: edge_ev = rise_in;
			PIM_COND_LO_ST: edge_ev = fall_in;
			default:        edge_ev = 1'b0;
		endcase
		// set wins over clear
		if (edge_ev) begin
			sticky_nxt = 1'b1;
		end else if (clr_in) begin
			sticky_nxt = 1'b0;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			sticky_r <= 1'b0;
		end else begin
			sticky_r <= sticky_nxt;
		end
	end

	always_comb begin
		case (pim_cond_t'(cond_in))
			PIM_COND_TRUE:  hit_out = 1'b1;
			PIM_COND_HIGH:  hit_out = level_in;
			PIM_COND_LOW:   hit_out = ~level_in;
			PIM_COND_RISE:  hit_out = rise_in;
			PIM_COND_FALL:  hit_out = fall_in;
			PIM_COND_EDGE:  hit_out = rise_in | fall_in;
			PIM_COND_HI_ST: hit_out = sticky_r | rise_in;
			PIM_COND_LO_ST: hit_out = sticky_r | fall_in;
			default:        hit_out = 1'b0;
		endcase
	end
endmodule

// >>> pim_src_sel.sv
`timescale 1ns/1ps
// one pin selector with edge detection for a single source
module pim_src_sel
	import pim_pkg::*;
(
	input  wire logic                   core_clk_in,
	input  wire logic                   srst_in,
	input  wire logic [NUM_PINS-1:0]    pins_in,
	input  wire logic [SEL_W-1:0]       sel_in,
	output logic                        level_out,
	output logic                        rise_out,
	output logic                        fall_out
);
	logic prev_r;
	logic prev_nxt;
	logic cur;

	always_comb begin
		cur      = pins_in[sel_in];
		prev_nxt = cur;
	end

	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			prev_r <= 1'b0;
		end else begin
			prev_r <= prev_nxt;
		end
	end

	assign level_out = cur;
	assign rise_out  = cur & ~prev_r;
	assign fall_out  = ~cur & prev_r;
endmodule

// >>> pim_top.sv
`timescale 1ns/1ps
// pin interrupt and pattern match engine top level
module pim_top
	import pim_pkg::*;
(
	input  wire logic                   core_clk_in,
	input  wire logic                   srst_in,
	input  wire logic [NUM_PINS-1:0]    pins_in,
	input  wire logic                   low_power_in,
	input  wire logic [ADDR_W-1:0]      addr_in,
	input  wire logic [DATA_W-1:0]      wdata_in,
	input  wire logic                   wr_in,
	input  wire logic                   rd_in,
	output logic      [DATA_W-1:0]      rdata_out,
	output logic      [NUM_SRC-1:0]     pin_irq_out,
	output logic                        pin_irq_zero_out,
	output logic                        pin_irq_one_out,
	output logic                        cpu_event_notify_out,
	output logic                        match_pin_out,
	output logic                        wake_out,
	output logic                        irq_out
);
	import pim_pkg::*;

	// configuration state
	logic [NUM_SRC-1:0]   mode_r, mode_nxt;
	logic [NUM_SRC-1:0]   rise_en_r, rise_en_nxt;
	logic [NUM_SRC-1:0]   fall_en_r, fall_en_nxt;
	logic [NUM_SRC-1:0]   pol_r, pol_nxt;
	logic [NUM_SRC-1:0]   rise_pnd_r, rise_pnd_nxt;
	logic [NUM_SRC-1:0]   fall_pnd_r, fall_pnd_nxt;
	logic [1:0]           match_ctl_r, match_ctl_nxt;
	logic [DATA_W-1:0]    sel_lo_r, sel_lo_nxt;
	logic [DATA_W-1:0]    sel_hi_r, sel_hi_nxt;
	logic [NUM_SRC*3-1:0] slice_r, slice_nxt;
	logic [NUM_SRC-1:0]   endpt_r, endpt_nxt;
	logic [NUM_SRC-1:0]   stat_r, stat_nxt;
	logic [NUM_SRC-1:0]   mask_r, mask_nxt;
	logic [DATA_W-1:0]    rdata_r, rdata_nxt;

	// output state
	logic [NUM_SRC-1:0]   irq_vec_r, irq_vec_nxt;
	logic                 event_r, event_nxt;
	logic                 match_any_r, match_any_nxt;
	logic                 wake_r, wake_nxt;
	logic                 irq_r, irq_nxt;

	logic [NUM_SRC-1:0]   lvl;
	logic [NUM_SRC-1:0]   rise;
	logic [NUM_SRC-1:0]   fall;
	logic [NUM_SRC-1:0]   hit;
	logic [NUM_SRC-1:0]   term;
	logic [NUM_SRC-1:0]   plain_req;
	logic [NUM_SRC-1:0]   slice_clr;
	logic [NUM_SRC*SEL_W-1:0] sel_flat;

	// one-hot decode of a register address against the bus
	function automatic logic hit_reg(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
		hit_reg = (a == r);
	endfunction

	// selector fields: four six-bit fields per select register
	assign sel_flat = {sel_hi_r[4*SEL_W-1:0], sel_lo_r[4*SEL_W-1:0]};

	genvar g;
	generate
		for (g = 0; g < NUM_SRC; g++) begin : g_src
			pim_src_sel u_sel (
				.core_clk_in (core_clk_in),
				.srst_in     (srst_in),
				.pins_in     (pins_in),
				.sel_in      (sel_flat[g*SEL_W +: SEL_W]),
				.level_out   (lvl[g]),
				.rise_out    (rise[g]),
				.fall_out    (fall[g])
			);
			pim_slice u_slice (
				.core_clk_in (core_clk_in),
				.srst_in     (srst_in),
				.level_in    (lvl[g]),
				.rise_in     (rise[g]),
				.fall_in     (fall[g]),
				.cond_in     (slice_r[g*3 +: 3]),
				.clr_in      (slice_clr[g]),
				.hit_out     (hit[g])
			);
		end
	endgenerate

	// product terms: a term spans slices up to and including an endpoint
	always_comb begin
		logic acc;
		acc       = 1'b1;
		term      = '0;
		slice_clr = '0;
		for (int i = 0; i < NUM_SRC; i++) begin
			acc = acc & hit[i];
			if (endpt_r[i]) begin
				// term output at its endpoint slice
				term[i] = acc;
				acc     = 1'b1;
			end
		end
		for (int i = 0; i < NUM_SRC; i++) begin
			slice_clr[i] = |term;
		end
	end

	// plain interrupt requests per source
	always_comb begin
		for (int i = 0; i < NUM_SRC; i++) begin
			if (mode_r[i]) begin
				plain_req[i] = rise_en_r[i] & (lvl[i] ~^ pol_r[i]);
			end else begin
				plain_req[i] = rise_pnd_r[i] | fall_pnd_r[i];
			end
		end
	end

	// register writes, pending edges and interrupt status
	always_comb begin
		mode_nxt      = mode_r;
		rise_en_nxt   = rise_en_r;
		fall_en_nxt   = fall_en_r;
		pol_nxt       = pol_r;
		rise_pnd_nxt  = rise_pnd_r;
		fall_pnd_nxt  = fall_pnd_r;
		match_ctl_nxt = match_ctl_r;
		sel_lo_nxt    = sel_lo_r;
		sel_hi_nxt    = sel_hi_r;
		slice_nxt     = slice_r;
		endpt_nxt     = endpt_r;
		stat_nxt      = stat_r;
		mask_nxt      = mask_r;
		if (wr_in) begin
			if (hit_reg(addr_in, REG_MODE))     mode_nxt = wdata_in[NUM_SRC-1:0];
			if (hit_reg(addr_in, REG_RISE_EN))  rise_en_nxt = wdata_in[NUM_SRC-1:0];
			if (hit_reg(addr_in, REG_FALL_EN))  fall_en_nxt = wdata_in[NUM_SRC-1:0];
			if (hit_reg(addr_in, REG_LVL_POL))  pol_nxt = wdata_in[NUM_SRC-1:0];
			if (hit_reg(addr_in, REG_MATCH_EN)) match_ctl_nxt = wdata_in[1:0];
			if (hit_reg(addr_in, REG_SEL_LO))   sel_lo_nxt = wdata_in;
			if (hit_reg(addr_in, REG_SEL_HI))   sel_hi_nxt = wdata_in;
			if (hit_reg(addr_in, REG_SLICE_LO)) slice_nxt[11:0] = wdata_in[11:0];
			if (hit_reg(addr_in, REG_SLICE_HI)) slice_nxt[23:12] = wdata_in[11:0];
			if (hit_reg(addr_in, REG_ENDPT))    endpt_nxt = wdata_in[NUM_SRC-1:0];
			if (hit_reg(addr_in, REG_IRQ_MASK)) mask_nxt = wdata_in[NUM_SRC-1:0];
			// write one to clear pending edges
			if (hit_reg(addr_in, REG_RISE_PND)) rise_pnd_nxt = rise_pnd_r & ~wdata_in[NUM_SRC-1:0];
			if (hit_reg(addr_in, REG_FALL_PND)) fall_pnd_nxt = fall_pnd_r & ~wdata_in[NUM_SRC-1:0];
		end
		if (rd_in && hit_reg(addr_in, REG_IRQ_STAT)) begin
			stat_nxt = '0;
		end
		// new edges set pending, winning over clear
		rise_pnd_nxt = rise_pnd_nxt | (rise & rise_en_r & ~mode_r);
		fall_pnd_nxt = fall_pnd_nxt | (fall & fall_en_r & ~mode_r);
		stat_nxt     = stat_nxt | irq_vec_nxt;
	end

	// request outputs
	always_comb begin
		if (match_ctl_r[MATCH_EN_BIT]) begin
			// matcher mode, one request per term
			irq_vec_nxt = term;
		end else begin
			irq_vec_nxt = plain_req;
		end
		match_any_nxt = match_ctl_r[MATCH_EN_BIT] & (|term);
		event_nxt     = match_any_nxt & match_ctl_r[EVENT_EN_BIT];
		wake_nxt      = low_power_in & ~match_ctl_r[MATCH_EN_BIT] & (|plain_req);
		irq_nxt       = |(stat_nxt & mask_r);
	end

	// register read data, one cycle after the strobe
	always_comb begin
		rdata_nxt = UNMAPPED_RD;
		if (rd_in) begin
			case (addr_in)
				REG_MODE:     rdata_nxt = {24'h000000, mode_r};
				REG_RISE_EN:  rdata_nxt = {24'h000000, rise_en_r};
				REG_FALL_EN:  rdata_nxt = {24'h000000, fall_en_r};
				REG_LVL_POL:  rdata_nxt = {24'h000000, pol_r};
				REG_RISE_PND: rdata_nxt = {24'h000000, rise_pnd_r};
				REG_FALL_PND: rdata_nxt = {24'h000000, fall_pnd_r};
				REG_MATCH_EN: rdata_nxt = {30'h00000000, match_ctl_r};
				REG_SEL_LO:   rdata_nxt = sel_lo_r;
				REG_SEL_HI:   rdata_nxt = sel_hi_r;
				REG_SLICE_LO: rdata_nxt = {20'h00000, slice_r[11:0]};
				REG_SLICE_HI: rdata_nxt = {20'h00000, slice_r[23:12]};
				REG_ENDPT:    rdata_nxt = {24'h000000, endpt_r};
				REG_IRQ_STAT: rdata_nxt = {24'h000000, stat_r};
				REG_IRQ_MASK: rdata_nxt = {24'h000000, mask_r};
				REG_PIN_STAT: rdata_nxt = {24'h000000, lvl};
				default:      rdata_nxt = UNMAPPED_RD;
			endcase
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			mode_r      <= RST_BYTE;
			rise_en_r   <= RST_BYTE;
			fall_en_r   <= RST_BYTE;
			pol_r       <= RST_BYTE;
			rise_pnd_r  <= RST_BYTE;
			fall_pnd_r  <= RST_BYTE;
			match_ctl_r <= 2'h0;
			sel_lo_r    <= RST_SEL;
			sel_hi_r    <= RST_SEL;
			slice_r     <= RST_SLICE;
			endpt_r     <= RST_BYTE;
			stat_r      <= RST_BYTE;
			mask_r      <= RST_BYTE;
			rdata_r     <= UNMAPPED_RD;
			irq_vec_r   <= RST_BYTE;
			event_r     <= 1'b0;
			match_any_r <= 1'b0;
			wake_r      <= 1'b0;
			irq_r       <= 1'b0;
		end else begin
			mode_r      <= mode_nxt;
			rise_en_r   <= rise_en_nxt;
			fall_en_r   <= fall_en_nxt;
			pol_r       <= pol_nxt;
			rise_pnd_r  <= rise_pnd_nxt;
			fall_pnd_r  <= fall_pnd_nxt;
			match_ctl_r <= match_ctl_nxt;
			sel_lo_r    <= sel_lo_nxt;
			sel_hi_r    <= sel_hi_nxt;
			slice_r     <= slice_nxt;
			endpt_r     <= endpt_nxt;
			stat_r      <= stat_nxt;
			mask_r      <= mask_nxt;
			rdata_r     <= rdata_nxt;
			irq_vec_r   <= irq_vec_nxt;
			event_r     <= event_nxt;
			match_any_r <= match_any_nxt;
			wake_r      <= wake_nxt;
			irq_r       <= irq_nxt;
		end
	end

	assign rdata_out            = rdata_r;
	assign pin_irq_out          = irq_vec_r;
	// first two requests as dma triggers
	assign pin_irq_zero_out     = irq_vec_r[0];
	assign pin_irq_one_out      = irq_vec_r[1];
	assign cpu_event_notify_out = event_r;
	// match output routable to a pin
	assign match_pin_out        = match_any_r;
	assign wake_out             = wake_r;
	assign irq_out              = irq_r;
endmodule

// >>> pim_top_monitor.sv
// port checker for the pin interrupt block
`timescale 1ns/1ps
module pim_top_monitor
	import pim_pkg::*;
(
	input  wire logic                core_clk_in,
	input  wire logic                srst_in,
	input  wire logic [NUM_PINS-1:0] pins_in,
	input  wire logic                low_power_in,
	input  wire logic [ADDR_W-1:0]   addr_in,
	input  wire logic [DATA_W-1:0]   wdata_in,
	input  wire logic                wr_in,
	input  wire logic                rd_in,
	input  wire logic [DATA_W-1:0]   rdata_out,
	input  wire logic [NUM_SRC-1:0]  pin_irq_out,
	input  wire logic                pin_irq_zero_out,
	input  wire logic                pin_irq_one_out,
	input  wire logic                cpu_event_notify_out,
	input  wire logic                match_pin_out,
	input  wire logic                wake_out,
	input  wire logic                irq_out
);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (srst_in);
	property p_dma_zero;
		pin_irq_zero_out == pin_irq_out[0];
	endproperty
	a_dma_zero: assert property (p_dma_zero) else $error("dma trigger zero differs");
	property p_dma_one;
		pin_irq_one_out == pin_irq_out[1];
	endproperty
	a_dma_one: assert property (p_dma_one) else $error("dma trigger one differs");
	property p_wake_lp;
		wake_out |-> $past(low_power_in) && (pin_irq_out != 8'h00);
	endproperty
	a_wake_lp: assert property (p_wake_lp) else $error("wake without request");
	property p_no_match_wake;
		wake_out |-> !match_pin_out;
	endproperty
	a_no_match_wake: assert property (p_no_match_wake) else $error("wake from match");
	property p_event_match;
		cpu_event_notify_out |-> match_pin_out;
	endproperty
	a_event_match: assert property (p_event_match) else $error("event without match");
	property p_rd_idle;
		!$past(rd_in) |-> rdata_out == 32'h00000000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
	property p_rd_unmapped;
		rd_in && (addr_in > REG_PIN_STAT) |=> rdata_out == UNMAPPED_RD;
	endproperty
	a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read nonzero");
	property p_rst_quiet;
		disable iff (1'b0) srst_in |=> (pin_irq_out == 8'h00) && !irq_out && !wake_out && !cpu_event_notify_out;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
	c_event: cover property (cpu_event_notify_out);
	c_wake: cover property (wake_out);
	c_irq: cover property (irq_out);
endmodule

bind pim_top pim_top_monitor u_pim_top_monitor (.core_clk_in(core_clk_in), .srst_in(srst_in),
	.pins_in(pins_in), .low_power_in(low_power_in), .addr_in(addr_in), .wdata_in(wdata_in),
	.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pin_irq_out(pin_irq_out),
	.pin_irq_zero_out(pin_irq_zero_out), .pin_irq_one_out(pin_irq_one_out),
	.cpu_event_notify_out(cpu_event_notify_out), .match_pin_out(match_pin_out),
	.wake_out(wake_out), .irq_out(irq_out));

// >>> pim_top_tb_top.sv
// self-checking testbench for the pin interrupt block
`timescale 1ns/1ps
module pim_top_tb_top;
	import pim_pkg::*;
	logic                core_clk_in, srst_in, low_power_in, wr_in, rd_in, ev_seen;
	logic [ADDR_W-1:0]   addr_in;
	logic [DATA_W-1:0]   wdata_in, rdata_out;
	logic [NUM_PINS-1:0] tgt, pins_in;
	logic [NUM_SRC-1:0]  pin_irq_out;
	logic                pin_irq_zero_out, pin_irq_one_out, cpu_event_notify_out, match_pin_out, wake_out, irq_out;
	int                  error_cnt, n_tests, cyc;

	pim_top u_pim_top (.core_clk_in(core_clk_in), .srst_in(srst_in), .pins_in(pins_in),
		.low_power_in(low_power_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
		.rd_in(rd_in), .rdata_out(rdata_out), .pin_irq_out(pin_irq_out),
		.pin_irq_zero_out(pin_irq_zero_out), .pin_irq_one_out(pin_irq_one_out),
		.cpu_event_notify_out(cpu_event_notify_out), .match_pin_out(match_pin_out),
		.wake_out(wake_out), .irq_out(irq_out));
	pim_pin_host u_pim_pin_host (.core_clk_in(core_clk_in), .tgt_in(tgt),
		.event_in(cpu_event_notify_out), .pins_out(pins_in), .ev_seen_out(ev_seen));

	initial begin
		core_clk_in = 1'b0;
		forever #5 core_clk_in = ~core_clk_in;
	end

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge core_clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge core_clk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		@(posedge core_clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge core_clk_in);
		rd_in <= 1'b0;
		#1;
		chk(rdata_out, exp);
	endtask
	task automatic setp(input int i, input logic v);
		@(posedge core_clk_in);
		tgt[i] <= v;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge core_clk_in);
		#1;
	endtask
	task automatic wait_irq(input int i, input logic v);
		int k;
		k = 0;
		#1;
		while (pin_irq_out[i] !== v && k < 8) begin
			@(posedge core_clk_in);
			#1;
			k++;
		end
		chk(pin_irq_out[i], v);
	endtask

	always @(posedge core_clk_in) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			give_verdict();
		end
	end

	initial begin
		srst_in = 1'b1;
		low_power_in = 1'b0;
		wr_in = 1'b0;
		rd_in = 1'b0;
		addr_in = '0;
		wdata_in = '0;
		tgt = '0;
		error_cnt = 0;
		n_tests = 0;
		cyc = 0;
		repeat (20) @(posedge core_clk_in);
		srst_in <= 1'b0;
		for (int a = 0; a < 16; a++) rd(ADDR_W'(a * 4), RST_SEL);
		wr(REG_IRQ_MASK, 32'h00000002);
		rd(REG_IRQ_MASK, 32'h00000002);
		wr(REG_SEL_LO, 32'h00000A05);
		wr(REG_RISE_EN, 32'h00000001);
		wr(REG_FALL_EN, 32'h00000003);
		setp(5, 1'b1);
		wait_irq(0, 1'b1);
		chk(pin_irq_zero_out, 1'b1);
		step(1);
		chk(irq_out, 1'b0);
		setp(5, 1'b0);
		step(4);
		chk(pin_irq_out[0], 1'b1);
		rd(REG_RISE_PND, 32'h00000001);
		wr(REG_RISE_PND, 32'h00000001);
		wr(REG_FALL_PND, 32'h00000001);
		wait_irq(0, 1'b0);
		setp(40, 1'b1);
		step(4);
		chk(pin_irq_out[1], 1'b0);
		setp(40, 1'b0);
		wait_irq(1, 1'b1);
		chk(pin_irq_one_out, 1'b1);
		step(2);
		chk(irq_out, 1'b1);
		wr(REG_FALL_PND, 32'h00000002);
		rd(REG_IRQ_STAT, 32'h00000003);
		step(2);
		chk(irq_out, 1'b0);
		wr(REG_MODE, 32'h00000001);
		wr(REG_LVL_POL, 32'h00000000);
		wait_irq(0, 1'b1);
		setp(5, 1'b1);
		wait_irq(0, 1'b0);
		wr(REG_LVL_POL, 32'h00000001);
		wait_irq(0, 1'b1);
		rd(REG_PIN_STAT, 32'h00000001);
		@(posedge core_clk_in);
		low_power_in <= 1'b1;
		step(3);
		chk(wake_out, 1'b1);
		wr(REG_SLICE_LO, 32'h00000001);
		wr(REG_ENDPT, 32'h00000001);
		wr(REG_MATCH_EN, 32'h00000003);
		step(4);
		chk(match_pin_out, 1'b1);
		chk(pin_irq_out[0], 1'b1);
		chk(wake_out, 1'b0);
		chk(ev_seen, 1'b1);
		setp(5, 1'b0);
		step(4);
		chk(match_pin_out, 1'b0);
		chk(pin_irq_out[0], 1'b0);
		wr(REG_SLICE_LO, 32'h00000002);
		step(4);
		chk(pin_irq_out[0], 1'b1);
		give_verdict();
	end
endmodule
